// ### rtl/mie_pkg.sv
// Shared constants and types of the instruction execute unit
package mie_pkg;
    // System register window, byte addresses
    localparam logic [7:0] SYS_FIRST = 8'h80;
    localparam logic [7:0] SYS_LAST  = 8'h87;
    // System register indices inside the window
    localparam logic [2:0] IDX_R     = 3'h2;
    localparam logic [2:0] IDX_Z     = 3'h3;
    localparam logic [2:0] IDX_Y     = 3'h4;
    localparam logic [2:0] IDX_PROGRAM_FLAG_REGISTER = 3'h6;
    localparam logic [2:0] IDX_PAGE  = 3'h7;
    // Field positions in program_flag_register and the page register
    localparam int FLG_Z    = 0;
    localparam int FLG_DC   = 1;
    localparam int FLG_C    = 2;
    localparam int FLG_NPD  = 6;
    localparam int FLG_NT0  = 7;
    localparam int PAGE_LO  = 0;
    localparam int BANK_BIT = 4;
    localparam logic [7:0] SHADOW_MASK = 8'h3f;
    // AXI4-Lite register offsets and reset values
    localparam logic [7:0]  REG_CTRL  = 8'h00;
    localparam logic [7:0]  REG_STAT  = 8'h04;
    localparam logic [7:0]  REG_PC    = 8'h08;
    localparam logic [7:0]  REG_CYC   = 8'h0c;
    localparam logic [1:0]  CTRL_RST  = 2'h1;
    localparam int          CTRL_RUN  = 0;
    localparam int          CTRL_GIE  = 1;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;
    localparam logic [15:0] PC_RST    = 16'h0000;

    typedef enum logic [4:0] {
        OP_NOP  = 5'h00, OP_MOV  = 5'h01, OP_XCH  = 5'h02, OP_PROGRAM_TABLE_READ = 5'h03,
        OP_ADD  = 5'h04, OP_ADC  = 5'h05, OP_SUB  = 5'h06, OP_SBC  = 5'h07,
        OP_AND  = 5'h08, OP_OR   = 5'h09, OP_XOR  = 5'h0a, OP_SWAP = 5'h0b,
        OP_RRC  = 5'h0c, OP_RLC  = 5'h0d, OP_CLR  = 5'h0e, OP_BCLR = 5'h0f,
        OP_BSET = 5'h10, OP_CMPS = 5'h11, OP_INCREMENT_SKIP_IF_ZERO = 5'h12, OP_DECREMENT_SKIP_IF_ZERO = 5'h13,
        OP_SKIP_IF_BIT_CLEAR = 5'h14, OP_SKIP_IF_BIT_SET = 5'h15, OP_JMP  = 5'h16, OP_CALL = 5'h17,
        OP_RET  = 5'h18, OP_RETURN_FROM_INTERRUPT = 5'h19, OP_PUSH = 5'h1a, OP_POP  = 5'h1b
    } mie_op_t;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_STALL = 3'b010,
        ST_TABLE = 3'b100
    } mie_state_t;

    typedef struct packed {
        mie_op_t     op;
        logic        to_mem;
        logic        use_imm;
        logic        bank0;
        logic [2:0]  bit_idx;
        logic [7:0]  addr;
        logic [7:0]  imm;
        logic [13:0] dest;
    } mie_ins_t;
endpackage : mie_pkg

// ### rtl/mie_core.sv
// Instruction execute unit of the 8-bit core with AXI4-Lite status port
`timescale 1ns/10ps
module mie_core
    import mie_pkg::*;
#(
    parameter int BANK_W   = 1,
    parameter int STACK_W  = 3
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    input  wire mie_ins_t    i_ins,
    input  wire logic        i_ins_valid,
    output logic             o_ins_ready,
    output logic             o_rom_rd,
    output logic [15:0]      o_rom_addr,
    input  wire logic [15:0] i_rom_data,
    input  wire logic        i_wdt_timeout,
    input  wire logic        i_power_down,
    output logic [15:0]      o_pc,
    output logic             o_gie,
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready
);
    localparam int RAM_D = 2 ** (BANK_W + 7);
    localparam int STK_D = 2 ** STACK_W;

    function automatic logic sys_hit(input logic [7:0] a);
        sys_hit = (a >= SYS_FIRST) && (a <= SYS_LAST);
    endfunction : sys_hit

    // {carry, decimal carry, result}; subtraction is addition of the complement
    function automatic logic [9:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic sub, input logic cin);
        logic [7:0] bb;
        logic [4:0] lo;
        logic [8:0] sum;
        bb  = sub ? ~b : b;
        lo  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        alu_add = {sum[8], lo[4], sum[7:0]};
    endfunction : alu_add

    logic [7:0]         ram_mem [RAM_D];
    logic [7:0]         sys_ff [8];
    logic [15:0]        stk_mem [STK_D];
    logic [STACK_W-1:0] sp_ff;
    logic [7:0]         acc_ff, sh_acc_ff, sh_flg_ff;
    logic [15:0]        pc_ff;
    logic [31:0]        cyc_ff;
    logic [1:0]         ctrl_ff;
    logic               skip_ff, gie_ff;
    logic [1:0]         wdt_sync_ff, pd_sync_ff;
    mie_state_t         state_ff;

    // Status pins come from outside the clock domain
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wdt_sync_ff <= 2'b00;
            pd_sync_ff  <= 2'b00;
        end else if (i_ce) begin
            wdt_sync_ff <= {wdt_sync_ff[0], i_wdt_timeout};
            pd_sync_ff  <= {pd_sync_ff[0], i_power_down};
        end
    end

    logic                    take, exec;
    logic [7:0]              program_flag_register, mem_rd, opnd, res, wdata, nxt_acc;
    logic [BANK_W+6:0]       ram_idx;
    logic [9:0]              alu;
    logic                    mem_we, acc_we, wr_dest, flag_we, nxt_c, nxt_dc, nxt_z;
    logic                    nxt_skip, branch, push, pop, return_from_interrupt, save, restore, table_rd;
    logic [15:0]             nxt_pc;

    assign program_flag_register   = sys_ff[IDX_PROGRAM_FLAG_REGISTER];
    assign ram_idx = {i_ins.bank0 ? {BANK_W{1'b0}} : sys_ff[IDX_PAGE][BANK_BIT +: BANK_W],
                      i_ins.addr[6:0]};
    assign mem_rd  = i_ins.addr[7] ? (sys_hit(i_ins.addr) ? sys_ff[i_ins.addr[2:0]] : 8'h00)
                                   : ram_mem[ram_idx];
    assign opnd    = i_ins.use_imm ? i_ins.imm : mem_rd;
    assign o_ins_ready = (state_ff == ST_RUN) && ctrl_ff[CTRL_RUN];
    assign take    = i_ce && i_ins_valid && o_ins_ready;
    assign exec    = take && !skip_ff;

    always_comb begin
        alu      = alu_add(acc_ff, opnd, 1'b0, 1'b0);
        res      = opnd;
        wdata    = 8'h00;
        nxt_acc  = acc_ff;
        mem_we   = 1'b0;
        acc_we   = 1'b0;
        wr_dest  = 1'b0;
        flag_we  = 1'b0;
        nxt_c    = program_flag_register[FLG_C];
        nxt_dc   = program_flag_register[FLG_DC];
        nxt_z    = program_flag_register[FLG_Z];
        nxt_skip = 1'b0;
        branch   = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        return_from_interrupt     = 1'b0;
        save     = 1'b0;
        restore  = 1'b0;
        table_rd = 1'b0;
        nxt_pc   = pc_ff + 16'h0001;
        case (i_ins.op)
            OP_MOV: begin
                if (i_ins.to_mem) begin
                    wdata  = i_ins.use_imm ? i_ins.imm : acc_ff;
                    mem_we = !i_ins.use_imm || (i_ins.bank0 && sys_hit(i_ins.addr));
                end else begin
                    wr_dest = 1'b1;
                    if (i_ins.bank0 && !i_ins.use_imm) begin
                        flag_we = 1'b1;
                        nxt_z   = (opnd == 8'h00);
                    end
                end
            end
            OP_XCH: begin
                nxt_acc = mem_rd;
                acc_we  = 1'b1;
                wdata   = acc_ff;
                mem_we  = 1'b1;
            end
            OP_PROGRAM_TABLE_READ: table_rd = 1'b1;
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                alu = alu_add(acc_ff, opnd, i_ins.op inside {OP_SUB, OP_SBC},
                              (i_ins.op inside {OP_ADC, OP_SBC}) ? program_flag_register[FLG_C]
                                                                 : (i_ins.op == OP_SUB));
                res     = alu[7:0];
                wr_dest = 1'b1;
                flag_we = 1'b1;
                {nxt_c, nxt_dc} = alu[9:8];
                nxt_z   = (alu[7:0] == 8'h00);
            end
            OP_AND, OP_OR, OP_XOR: begin
                res     = (i_ins.op == OP_AND) ? (acc_ff & opnd) :
                          (i_ins.op == OP_OR)  ? (acc_ff | opnd) : (acc_ff ^ opnd);
                wr_dest = 1'b1;
                flag_we = 1'b1;
                nxt_z   = (res == 8'h00);
            end
            OP_SWAP: begin
                res     = {opnd[3:0], opnd[7:4]};
                wr_dest = 1'b1;
            end
            OP_RRC, OP_RLC: begin
                res     = (i_ins.op == OP_RRC) ? {program_flag_register[FLG_C], opnd[7:1]}
                                               : {opnd[6:0], program_flag_register[FLG_C]};
                nxt_c   = (i_ins.op == OP_RRC) ? opnd[0] : opnd[7];
                flag_we = 1'b1;
                wr_dest = 1'b1;
            end
            OP_CLR: mem_we = 1'b1;
            OP_BCLR, OP_BSET: begin
                wdata  = mem_rd;
                wdata[i_ins.bit_idx] = (i_ins.op == OP_BSET);
                mem_we = 1'b1;
            end
            OP_CMPS: begin
                alu      = alu_add(acc_ff, opnd, 1'b1, 1'b1);
                flag_we  = 1'b1;
                nxt_c    = alu[9];
                nxt_z    = (alu[7:0] == 8'h00);
                nxt_skip = (alu[7:0] == 8'h00);
            end
            OP_INCREMENT_SKIP_IF_ZERO, OP_DECREMENT_SKIP_IF_ZERO: begin
                res      = (i_ins.op == OP_INCREMENT_SKIP_IF_ZERO) ? opnd + 8'h01 : opnd - 8'h01;
                wr_dest  = 1'b1;
                nxt_skip = (res == 8'h00);
            end
            OP_SKIP_IF_BIT_CLEAR: nxt_skip = !opnd[i_ins.bit_idx];
            OP_SKIP_IF_BIT_SET: nxt_skip = opnd[i_ins.bit_idx];
            OP_JMP, OP_CALL: begin
                branch = 1'b1;
                push   = (i_ins.op == OP_CALL);
                nxt_pc = {sys_ff[IDX_PAGE][PAGE_LO +: 2], i_ins.dest};
            end
            OP_RET, OP_RETURN_FROM_INTERRUPT: begin
                branch = 1'b1;
                pop    = 1'b1;
                return_from_interrupt   = (i_ins.op == OP_RETURN_FROM_INTERRUPT);
                nxt_pc = stk_mem[sp_ff - STACK_W'(1)];
            end
            OP_PUSH: save = 1'b1;
            OP_POP: begin
                restore = 1'b1;
                nxt_acc = sh_acc_ff;
                acc_we  = 1'b1;
            end
            default: ;
        endcase
        if (wr_dest) begin
            if (i_ins.to_mem) begin
                wdata  = res;
                mem_we = 1'b1;
            end else begin
                nxt_acc = res;
                acc_we  = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_ff <= 8'h00;
        end else if (i_ce) begin
            if (state_ff == ST_TABLE) begin
                acc_ff <= i_rom_data[7:0];
            end else if (exec && acc_we) begin
                acc_ff <= nxt_acc;
            end
        end
    end

    // System registers; hardware status bits are refreshed every cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < 8; k++) begin
                sys_ff[k] <= 8'h00;
            end
        end else if (i_ce) begin
            if (exec && mem_we && sys_hit(i_ins.addr)) begin
                sys_ff[i_ins.addr[2:0]] <= wdata;
            end
            if (state_ff == ST_TABLE) begin
                sys_ff[IDX_R] <= i_rom_data[15:8];
            end
            if (exec && restore) begin
                sys_ff[IDX_PROGRAM_FLAG_REGISTER][5:0] <= sh_flg_ff[5:0];
            end else if (exec && flag_we) begin
                sys_ff[IDX_PROGRAM_FLAG_REGISTER][FLG_C]  <= nxt_c;
                sys_ff[IDX_PROGRAM_FLAG_REGISTER][FLG_DC] <= nxt_dc;
                sys_ff[IDX_PROGRAM_FLAG_REGISTER][FLG_Z]  <= nxt_z;
            end
            sys_ff[IDX_PROGRAM_FLAG_REGISTER][FLG_NT0] <= wdt_sync_ff[1];
            sys_ff[IDX_PROGRAM_FLAG_REGISTER][FLG_NPD] <= pd_sync_ff[1];
        end
    end

    // Data RAM holds no reset so it can map to a plain memory
    always_ff @(posedge i_clk) begin
        if (i_ce && exec && mem_we && !i_ins.addr[7]) begin
            ram_mem[ram_idx] <= wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sh_acc_ff <= 8'h00;
            sh_flg_ff <= 8'h00;
        end else if (i_ce && exec && save) begin
            sh_acc_ff <= acc_ff;
            sh_flg_ff <= program_flag_register & SHADOW_MASK;
        end
    end

    // Counter and return stack; the stack wraps silently on overflow
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pc_ff <= PC_RST;
            sp_ff <= '0;
        end else if (i_ce && take) begin
            pc_ff <= exec ? nxt_pc : pc_ff + 16'h0001;
            if (exec && push) begin
                sp_ff <= sp_ff + STACK_W'(1);
            end else if (exec && pop) begin
                sp_ff <= sp_ff - STACK_W'(1);
            end
        end
    end

    // Return stack holds no reset, like the data RAM
    always_ff @(posedge i_clk) begin
        if (i_ce && exec && push) begin
            stk_mem[sp_ff] <= pc_ff + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_RUN;
            skip_ff  <= 1'b0;
        end else if (i_ce) begin
            case (state_ff)
                ST_RUN: begin
                    if (take) begin
                        skip_ff <= exec && nxt_skip;
                        if (exec && table_rd) begin
                            state_ff <= ST_TABLE;
                        end else if (exec && (branch || (mem_we && !i_ins.addr[7]))) begin
                            state_ff <= ST_STALL;
                        end
                    end
                end
                ST_STALL, ST_TABLE: state_ff <= ST_RUN;
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    assign o_rom_rd   = (state_ff == ST_TABLE);
    assign o_rom_addr = {sys_ff[IDX_Y], sys_ff[IDX_Z]};
    assign o_pc       = pc_ff;
    assign o_gie      = gie_ff;

    // AXI4-Lite slave: address and data taken in either order
    logic        aw_got_ff, w_got_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bus_wr;
    assign o_s_axi_awready = !aw_got_ff && !o_s_axi_bvalid;
    assign o_s_axi_wready  = !w_got_ff && !o_s_axi_bvalid;
    assign o_s_axi_arready = !o_s_axi_rvalid;
    assign bus_wr = aw_got_ff && w_got_ff && !o_s_axi_bvalid;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_got_ff      <= 1'b0;
            w_got_ff       <= 1'b0;
            awaddr_ff      <= 8'h00;
            wdata_ff       <= 32'h0;
            wstrb_ff       <= 4'h0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end else if (i_ce) begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= i_s_axi_wdata;
                wstrb_ff <= i_s_axi_wstrb;
            end
            if (bus_wr) begin
                aw_got_ff      <= 1'b0;
                w_got_ff       <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= (awaddr_ff[7:4] == 4'h0) ? RESP_OKAY : RESP_SLV;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Interrupt return sets the enable even when software clears it together
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_ff <= CTRL_RST;
            gie_ff  <= 1'b0;
        end else if (i_ce) begin
            if (bus_wr && awaddr_ff == REG_CTRL && wstrb_ff[0]) begin
                ctrl_ff[CTRL_RUN] <= wdata_ff[CTRL_RUN];
                gie_ff <= wdata_ff[CTRL_GIE] || (exec && return_from_interrupt);
            end else if (exec && return_from_interrupt) begin
                gie_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cyc_ff <= 32'h0;
        end else if (i_ce && (take || state_ff != ST_RUN)) begin
            cyc_ff <= cyc_ff + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0;
            o_s_axi_rresp  <= RESP_OKAY;
        end else if (i_ce) begin
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rresp  <= RESP_OKAY;
                case (i_s_axi_araddr)
                    REG_CTRL: o_s_axi_rdata <= {30'h0, gie_ff, ctrl_ff[CTRL_RUN]};
                    REG_STAT: o_s_axi_rdata <= {12'h0, skip_ff, state_ff, program_flag_register, acc_ff};
                    REG_PC:   o_s_axi_rdata <= {16'h0, pc_ff};
                    REG_CYC:  o_s_axi_rdata <= cyc_ff;
                    default: begin
                        o_s_axi_rdata <= 32'h0;
                        o_s_axi_rresp <= RESP_SLV;
                    end
                endcase
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_call;
        exec && i_ins.op == OP_CALL;
    endsequence
    sequence s_skip_set;
        exec && nxt_skip;
    endsequence
    sequence s_discard;
        take && skip_ff;
    endsequence

    a_imm_move_range: assert property (exec && i_ins.op == OP_MOV && i_ins.use_imm
        && i_ins.to_mem && !sys_hit(i_ins.addr)
        |=> $stable(sys_ff[IDX_PROGRAM_FLAG_REGISTER][5:0]) && $stable(sys_ff[IDX_PAGE]) && o_ins_ready)
        else $error("immediate move hit register outside window");
    a_add_result: assert property (exec && i_ins.op == OP_ADC && !i_ins.to_mem
        |=> {program_flag_register[FLG_C], acc_ff} == 9'($past(acc_ff) + $past(opnd) + $past(program_flag_register[FLG_C])))
        else $error("add with carry wrong");
    a_sub_carry: assert property (exec && i_ins.op == OP_SUB && !i_ins.to_mem
        |=> program_flag_register[FLG_C] == ($past(acc_ff) >= $past(opnd)))
        else $error("subtract carry convention wrong");
    a_logic_flags: assert property (exec && i_ins.op inside {OP_AND, OP_OR, OP_XOR}
        |=> $stable(program_flag_register[FLG_C]) && $stable(program_flag_register[FLG_DC]))
        else $error("logic op touched carry");
    a_swap_acc: assert property (exec && i_ins.op == OP_SWAP && !i_ins.to_mem
        |=> acc_ff == {$past(opnd[3:0]), $past(opnd[7:4])})
        else $error("swap wrong");
    a_ram_write_stall: assert property (exec && mem_we && !i_ins.addr[7]
        |=> state_ff == ST_STALL && !o_ins_ready)
        else $error("missing write-back cycle");
    a_skip_discard: assert property (s_discard
        |=> $stable(acc_ff) && $stable(sys_ff[IDX_PROGRAM_FLAG_REGISTER][5:0]))
        else $error("skipped instruction took effect");
    a_skip_arm: assert property (s_skip_set |=> skip_ff)
        else $error("skip condition not remembered");
    a_skip_flag_set: assert property (exec && i_ins.op == OP_SKIP_IF_BIT_CLEAR
        && !opnd[i_ins.bit_idx] |=> skip_ff)
        else $error("bit test did not skip");
    a_call_push: assert property (s_call |=> stk_mem[$past(sp_ff)] == $past(pc_ff) + 16'h1
        ##1 state_ff == ST_RUN)
        else $error("call push wrong");
    a_return_from_interrupt_gie: assert property (exec && i_ins.op == OP_RETURN_FROM_INTERRUPT |=> o_gie)
        else $error("interrupt return left enable off");
    a_save_mask: assert property (exec && save
        |=> sh_flg_ff == {2'b00, $past(program_flag_register[5:0])} && sh_acc_ff == $past(acc_ff))
        else $error("status bits saved");
    a_table_addr: assert property (exec && table_rd
        |=> o_rom_rd && o_rom_addr == {$past(sys_ff[IDX_Y]), $past(sys_ff[IDX_Z])})
        else $error("table read address wrong");
    a_rotate_carry: assert property (exec && i_ins.op == OP_RRC
        |=> program_flag_register[FLG_C] == $past(opnd[0]))
        else $error("rotate carry wrong");
endmodule : mie_core

// ### test/mie_rom_model.sv
// Program memory model answering table reads
`timescale 1ns/10ps
module mie_rom_model (
    input  wire logic        i_clk,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    output logic      [15:0] o_data
);
    logic [15:0] last_ff = 16'h0;
    // Idle bus toggles so stale words never look valid
    assign o_data = i_rd ? (i_addr ^ 16'h3c5a) : ~last_ff;
    always_ff @(posedge i_clk) last_ff <= o_data;
endmodule : mie_rom_model

// ### test/mcu_8bit_instruction_execute_tb.sv
// Self-checking bench of the instruction execute unit
`timescale 1ns/10ps
module mcu_8bit_instruction_execute_tb;
    import mie_pkg::*;
    logic        i_clk, i_resetn, vld, rdy, rd, gie, awv, wv, bv, br, arv, rv, rr, awr, wr, arr;
    logic        wdt;
    logic [7:0]  awa, ara;
    logic [15:0] ra, rdat, pc;
    logic [31:0] wd, rdt;
    logic [3:0]  ws;
    logic [1:0]  brs, rrs;
    mie_ins_t    ins;
    int          mismatches, n_tests;
    mie_core i_dut (.i_clk, .i_resetn, .i_ce(1'b1), .i_ins(ins), .i_ins_valid(vld),
        .o_ins_ready(rdy), .o_rom_rd(rd), .o_rom_addr(ra), .i_rom_data(rdat),
        .i_wdt_timeout(wdt), .i_power_down(1'b0), .o_pc(pc), .o_gie(gie),
        .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
        .o_s_axi_bresp(brs), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
        .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rdt), .o_s_axi_rresp(rrs), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr));
    mie_rom_model i_rom (.i_clk, .i_rd(rd), .i_addr(ra), .o_data(rdat));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic chk(input logic [15:0] g, e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Handshakes decided on negedge samples, so no edge race
    task automatic ex(input mie_op_t op, input logic [7:0] a, im, input logic [1:0] m);
        logic t;
        @(posedge i_clk);
        ins <= '{op, m[1], m[0], 1'b1, 3'h0, a, im, {a[5:0], im}};
        vld <= 1'b1;
        do begin
            @(negedge i_clk);
            t = rdy;
            @(posedge i_clk);
        end while (!t);
        vld <= 1'b0;
    endtask : ex
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge i_clk);
        {awa, wd, awv, wv, br} <= {a, d, 3'b111};
        do begin
            @(negedge i_clk);
            {ta, tw, tb} = {awv & awr, wv & wr, bv};
            @(posedge i_clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
        br <= 1'b0;
        chk({14'h0, brs}, {14'h0, RESP_OKAY});
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [15:0] e, m, input logic [1:0] es);
        logic x, t;
        logic [31:0] d;
        logic [1:0] s;
        @(posedge i_clk);
        {ara, arv, rr} <= {a, 2'b11};
        do begin
            @(negedge i_clk);
            {x, t, d, s} = {arv & arr, rv, rdt, rrs};
            @(posedge i_clk);
            if (x) arv <= 1'b0;
        end while (!t);
        rr <= 1'b0;
        chk(d[15:0] & m, e);
        chk({14'h0, s}, {14'h0, es});
    endtask : axr
    task automatic t_run();
        axr(REG_CTRL, 16'h0001, 16'hffff, RESP_OKAY);
        axr(8'h10, 16'h0000, 16'h0000, RESP_SLV);
        axw(REG_CTRL, 32'h3);
        chk({15'h0, gie}, 16'h0001);
        ex(OP_MOV, 8'h00, 8'hff, 2'b01);
        ex(OP_ADD, 8'h00, 8'h01, 2'b01);
        axr(REG_STAT, 16'h0700, 16'hffff, RESP_OKAY);
        ex(OP_OR, 8'h00, 8'h0f, 2'b01);
        axr(REG_STAT, 16'h060f, 16'hffff, RESP_OKAY);
        ex(OP_SUB, 8'h00, 8'h10, 2'b01);
        axr(REG_STAT, 16'h02ff, 16'hffff, RESP_OKAY);
        ex(OP_MOV, 8'h00, 8'h05, 2'b01);
        ex(OP_CMPS, 8'h00, 8'h05, 2'b01);
        ex(OP_MOV, 8'h00, 8'h09, 2'b01);
        axr(REG_STAT, 16'h0005, 16'h00ff, RESP_OKAY);
        $display("alu and skip done");
    endtask : t_run
    task automatic t_flow();
        ex(OP_MOV, 8'h87, 8'h01, 2'b11);
        ex(OP_JMP, 8'h01, 8'h23, 2'b00);
        @(negedge i_clk);
        chk(pc, 16'h4123);
        chk({15'h0, rdy}, 16'h0000);
        ex(OP_MOV, 8'h84, 8'h12, 2'b11);
        ex(OP_MOV, 8'h83, 8'h34, 2'b11);
        ex(OP_PROGRAM_TABLE_READ, 8'h00, 8'h00, 2'b00);
        axr(REG_STAT, 16'h006e, 16'h00ff, RESP_OKAY);
        $display("jump and table done");
    endtask : t_flow
    // Cycle total counts every take, discarded ones too, plus stall and table-read cycles
    task automatic t_misc();
        ex(OP_MOV, 8'h00, 8'h5a, 2'b01);
        ex(OP_PUSH, 8'h00, 8'h00, 2'b00);
        wdt <= 1'b1;
        ex(OP_ADD, 8'h00, 8'h01, 2'b01);
        ex(OP_POP, 8'h00, 8'h00, 2'b00);
        axr(REG_STAT, 16'h875a, 16'hffff, RESP_OKAY);
        wdt <= 1'b0;
        ex(OP_MOV, 8'h10, 8'h00, 2'b10);
        @(negedge i_clk);
        chk({15'h0, rdy}, 16'h0000);
        ex(OP_SWAP, 8'h10, 8'h00, 2'b00);
        axr(REG_STAT, 16'h00a5, 16'h00ff, RESP_OKAY);
        ex(OP_CALL, 8'h02, 8'h00, 2'b00);
        @(negedge i_clk);
        chk(pc, 16'h4200);
        axw(REG_CTRL, 32'h1);
        chk({15'h0, gie}, 16'h0000);
        ex(OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00, 2'b00);
        @(negedge i_clk);
        chk(pc, 16'h412d);
        chk({15'h0, gie}, 16'h0001);
        ex(OP_MOV, 8'h90, 8'hff, 2'b11);
        ex(OP_RRC, 8'h00, 8'h03, 2'b01);
        ex(OP_ADC, 8'h00, 8'h7f, 2'b01);
        axr(REG_STAT, 16'h0601, 16'hffff, RESP_OKAY);
        ex(OP_SKIP_IF_BIT_CLEAR, 8'h86, 8'h00, 2'b00);
        ex(OP_MOV, 8'h00, 8'hee, 2'b01);
        ex(OP_INCREMENT_SKIP_IF_ZERO, 8'h00, 8'hff, 2'b01);
        ex(OP_MOV, 8'h00, 8'hee, 2'b01);
        axr(REG_STAT, 16'h0600, 16'hffff, RESP_OKAY);
        axr(REG_CYC, 16'h0020, 16'hffff, RESP_OKAY);
        $display("save, stack and skip done");
    endtask : t_misc
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        {i_resetn, vld, wdt, awv, wv, br, arv, rr, ins, awa, ara, wd} = '0;
        ws = 4'hf;
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_run();
        t_flow();
        t_misc();
        close_out();
    end
    initial begin
        #1000000;
        mismatches++;
        close_out();
    end
endmodule : mcu_8bit_instruction_execute_tb
